// [hdl/can_selective_wake_filter.v]
// Selective wake filter: serial register port, frame decoder and wake logic
// Overview of operation
// - Control bit 6 enables flexible-rate frame tolerance
// - Control bit 5 marks filter configuration valid
// - Control bit 4 enables selective frame wake-up
// - Mode bits 1:0 select offline/active/listen
// - Status bit 7 shows active mode
// - Status bit 6: overflow or invalid configuration
// - Status bit 5 mirrors configuration valid
// - Status bit 4 shows oscillator at frequency
// - Status bit 3 shows bus silence timeout
// - Status bit 1 supply low, mode 01 only
// - Status bit 0 shows transmit timeout
// - Monitor frames only when offline and all enabled
// - Extension select picks 11 or 29 bit
// - Mask bit one makes identifier bit don't-care
// - Nonzero length needs a masked data one
// - Single byte compares against last data mask
// - Zero lengths both wake regardless of data masks
// - Length mismatch ignores data, no wake
// - Filter off: identifier and good CRC wake
// - Filter on: id, no remote, length, data, CRC
// - Error counter over 31 sets flag, wakes
// - Filter register writes clear configuration valid
// - Without selective wake, standard pattern wakes
// - Six bus bit rates supported
// - Rate field codes, reserved codes pick 500k
// - Tolerated flexible frames decrement, never wake
`include "can_swf_defs.vh"
module can_selective_wake_filter #(
	parameter [16:0] SILENCE_CYC = 17'h1_E848
) (
	input  wire mclk,
	input  wire rst_b,
	input  wire ce,
	input  wire spi_sck,
	input  wire spi_sdi,
	input  wire spi_cs_b,
	output reg  spi_sdo,
	output reg  spi_sdo_oe,
	input  wire can_rx,
	input  wire normal_mode,
	input  wire bus_wake_en,
	input  wire supply_low,
	input  wire osc_locked,
	input  wire tx_timeout,
	input  wire bias_on,
	input  wire std_wake_pattern,
	input  wire wake_clr,
	output reg  bus_wake_flag,
	output reg  frame_error_overflow,
	output reg  active_mode
);
	localparam S_IDLE  = 3'h0;
	localparam S_READY = 3'h1;
	localparam S_HDR   = 3'h2;
	localparam S_DATA  = 3'h3;
	localparam S_CRC   = 3'h4;
	localparam S_DEL   = 3'h5;
	localparam [7:0] CTRL_RV = `CTRL_RST;
	localparam [7:0] FCTL_RV = `FCTL_RST;

	function [3:0] nbytes;
		input [3:0] d;
		begin
			nbytes = d[3] ? 4'h8 : d;
		end
	endfunction

	reg         fd_tolerance_en_reg;
	reg         filter_config_valid_reg;
	reg         selective_wake_en_reg;
	reg  [1:0]  transceiver_mode_sel_reg;
	reg  [2:0]  bit_rate_sel_reg;
	reg  [28:0] id_reg;
	reg  [28:0] mask_reg;
	reg         id_extended_select_reg;
	reg         data_filter_en_reg;
	reg  [3:0]  data_length_setting_reg;
	reg  [16:0] sil_cnt_reg;

	// Serial port: every pin passes three flops, a level counts once the last two agree
	reg  [2:0]  sck_s_reg;
	reg  [2:0]  sdi_s_reg;
	reg  [2:0]  cs_s_reg;
	reg         sck_f_reg;
	reg         sdi_f_reg;
	reg         cs_f_reg;
	reg  [3:0]  sbit_reg;
	reg  [7:0]  sin_reg;
	reg  [6:0]  saddr_reg;
	reg         srd_reg;
	reg  [7:0]  sout_reg;
	reg  [7:0]  rdv;
	wire        sck_ok   = (sck_s_reg[1] == sck_s_reg[2]);
	wire        sck_rise = sck_ok && sck_s_reg[2] && !sck_f_reg && !cs_f_reg;
	wire        sck_fall = sck_ok && !sck_s_reg[2] && sck_f_reg && !cs_f_reg;
	wire [7:0]  sin_nx   = {sin_reg[6:0], sdi_f_reg};
	wire [6:0]  rd_addr  = sin_nx[7:1];
	wire        wr_go    = sck_rise && sbit_reg == 4'hF && !srd_reg;
	wire        dm_we    = wr_go && saddr_reg[6:3] == `A_DM_HI;
	wire [7:0]  dm_rd_a;
	wire [7:0]  dm_rd_b;

	// Frame decoder
	reg  [2:0]  st_reg;
	reg  [5:0]  cnt_reg;
	reg  [39:0] sh_reg;
	reg  [14:0] crc_reg;
	reg         ide_reg;
	reg         rtr_reg;
	reg  [3:0]  rdlc_reg;
	reg  [3:0]  rn_reg;
	reg         idm_reg;
	reg         dmatch_reg;
	reg         crc_ok_reg;
	reg  [5:0]  ecnt_reg;
	reg         wake_hit_reg;
	reg         mon_q_reg;
	wire        bit_vld;
	wire        bval;
	wire        stuff_err;
	wire        bus_idle;
	wire        rx_edge;
	wire        offline  = !normal_mode || transceiver_mode_sel_reg == 2'b00;
	wire        pn_on    = selective_wake_en_reg && filter_config_valid_reg;
	wire        pn_mon   = offline && bus_wake_en && pn_on;
	// A stuff bit may follow the last crc bit, so the delimiter slot is still destuffed
	wire        stuff_en = (st_reg >= S_HDR) && (st_reg <= S_DEL);
	wire [39:0] sh_nx    = {sh_reg[38:0], bval};
	wire [14:0] crc_nx   = {crc_reg[13:0], 1'b0} ^ ((crc_reg[14] ^ bval) ? `CRC_POLY : 15'h0000);
	wire        hdr_last = ide_reg ? (cnt_reg == 6'h26) : (cnt_reg == 6'h12);
	wire [28:0] rx_id    = ide_reg ? {sh_nx[37:27], sh_nx[24:7]} : {sh_nx[17:7], 18'h0_0000};
	wire [28:0] cmp_m    = ide_reg ? ~mask_reg : {~mask_reg[28:18], 18'h0_0000};
	wire        fdf      = ide_reg ? sh_nx[5] : sh_nx[4];
	wire [3:0]  rx_n     = sh_nx[6] ? 4'h0 : nbytes(sh_nx[3:0]);
	wire [3:0]  cfg_n    = nbytes(data_length_setting_reg);
	wire [3:0]  ma       = 4'h8 - cfg_n + {1'b0, cnt_reg[5:3]};
	wire [2:0]  rn_m1    = rn_reg[2:0] - 3'h1;
	wire        err_in   = stuff_en && stuff_err;
	wire        len_ok   = !rtr_reg && rn_reg == cfg_n && nbytes(rdlc_reg) == cfg_n;
	wire        frm_wake = idm_reg && (!data_filter_en_reg ||
		(len_ok && (cfg_n == 4'h0 || dmatch_reg)));

	can_bit_sampler u_samp (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.ce        (ce),
		.rx_pin    (can_rx),
		.rate_sel  (bit_rate_sel_reg),
		.stuff_en  (stuff_en),
		.bit_vld   (bit_vld),
		.bit_val   (bval),
		.stuff_err (stuff_err),
		.bus_idle  (bus_idle),
		.rx_edge   (rx_edge)
	);

	can_dmask_mem u_dm (
		.mclk  (mclk),
		.rst_b (rst_b),
		.ce    (ce),
		.we    (dm_we),
		.waddr (saddr_reg[2:0]),
		.wdata (sin_nx),
		.ra_a  (ma[2:0]),
		.rd_a  (dm_rd_a),
		.ra_b  (sin_reg[2:0]),
		.rd_b  (dm_rd_b)
	);

	always @* begin
		rdv = 8'h00;
		case (rd_addr)
		`A_CTRL: rdv = {1'b0, fd_tolerance_en_reg, filter_config_valid_reg,
			selective_wake_en_reg, 2'b00, transceiver_mode_sel_reg};
		`A_STAT: rdv = {active_mode,
			frame_error_overflow || !filter_config_valid_reg,
			filter_config_valid_reg,
			osc_locked,
			sil_cnt_reg == SILENCE_CYC,
			1'b0,
			supply_low && transceiver_mode_sel_reg == 2'b01,
			tx_timeout};
		`A_RATE: rdv = {5'h00, bit_rate_sel_reg};
		`A_ID0:  rdv = id_reg[7:0];
		`A_ID1:  rdv = id_reg[15:8];
		`A_ID2:  rdv = id_reg[23:16];
		`A_ID3:  rdv = {3'h0, id_reg[28:24]};
		`A_MSK0: rdv = mask_reg[7:0];
		`A_MSK1: rdv = mask_reg[15:8];
		`A_MSK2: rdv = mask_reg[23:16];
		`A_MSK3: rdv = {3'h0, mask_reg[28:24]};
		`A_FCTL: rdv = {id_extended_select_reg, data_filter_en_reg, 2'b00,
			data_length_setting_reg};
		default: rdv = (rd_addr[6:3] == `A_DM_HI) ? dm_rd_b : 8'h00;
		endcase
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sck_s_reg  <= 3'h0;
			sdi_s_reg  <= 3'h0;
			cs_s_reg   <= 3'h7;
			sck_f_reg  <= 1'b0;
			sdi_f_reg  <= 1'b0;
			cs_f_reg   <= 1'b1;
			sbit_reg   <= 4'h0;
			sin_reg    <= 8'h00;
			saddr_reg  <= 7'h00;
			srd_reg    <= 1'b1;
			sout_reg   <= 8'h00;
			spi_sdo    <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else if (ce) begin
			sck_s_reg  <= {sck_s_reg[1:0], spi_sck};
			sdi_s_reg  <= {sdi_s_reg[1:0], spi_sdi};
			cs_s_reg   <= {cs_s_reg[1:0], spi_cs_b};
			if (sck_ok)
				sck_f_reg <= sck_s_reg[2];
			if (sdi_s_reg[1] == sdi_s_reg[2])
				sdi_f_reg <= sdi_s_reg[2];
			if (cs_s_reg[1] == cs_s_reg[2])
				cs_f_reg <= cs_s_reg[2];
			spi_sdo_oe <= !cs_f_reg;
			if (cs_f_reg) begin
				sbit_reg <= 4'h0;
				sout_reg <= 8'h00;
				spi_sdo  <= 1'b0;
			end else if (sck_rise) begin
				sin_reg  <= sin_nx;
				sbit_reg <= sbit_reg + 4'h1;
				if (sbit_reg == 4'h7) begin
					saddr_reg <= rd_addr;
					srd_reg   <= sin_nx[0];
					sout_reg  <= rdv;
				end
			end else if (sck_fall) begin
				spi_sdo  <= sout_reg[7];
				sout_reg <= {sout_reg[6:0], 1'b0};
			end
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fd_tolerance_en_reg      <= CTRL_RV[`C_FD];
			filter_config_valid_reg  <= CTRL_RV[`C_CFG];
			selective_wake_en_reg    <= CTRL_RV[`C_SEL];
			transceiver_mode_sel_reg <= CTRL_RV[1:0];
			bit_rate_sel_reg         <= `RATE_RST;
			id_reg                   <= `ID_RST;
			mask_reg                 <= `ID_RST;
			id_extended_select_reg   <= FCTL_RV[`F_IDE];
			data_filter_en_reg       <= FCTL_RV[`F_DATA_FILTER_EN];
			data_length_setting_reg  <= FCTL_RV[3:0];
		end else if (ce && wr_go) begin
			if ((saddr_reg >= `A_RATE && saddr_reg <= `A_FCTL) || saddr_reg[6:3] == `A_DM_HI)
				filter_config_valid_reg <= 1'b0;
			case (saddr_reg)
			`A_CTRL: begin
				fd_tolerance_en_reg      <= sin_nx[`C_FD];
				filter_config_valid_reg  <= sin_nx[`C_CFG];
				selective_wake_en_reg    <= sin_nx[`C_SEL];
				transceiver_mode_sel_reg <= sin_nx[1:0];
			end
			`A_RATE: bit_rate_sel_reg <= sin_nx[2:0];
			`A_ID0:  id_reg[7:0]      <= sin_nx;
			`A_ID1:  id_reg[15:8]     <= sin_nx;
			`A_ID2:  id_reg[23:16]    <= sin_nx;
			`A_ID3:  id_reg[28:24]    <= sin_nx[4:0];
			`A_MSK0: mask_reg[7:0]    <= sin_nx;
			`A_MSK1: mask_reg[15:8]   <= sin_nx;
			`A_MSK2: mask_reg[23:16]  <= sin_nx;
			`A_MSK3: mask_reg[28:24]  <= sin_nx[4:0];
			`A_FCTL: begin
				id_extended_select_reg  <= sin_nx[`F_IDE];
				data_filter_en_reg      <= sin_nx[`F_DATA_FILTER_EN];
				data_length_setting_reg <= sin_nx[3:0];
			end
			default: ;
			endcase
		end
	end

	// Active needs the supply up to enter; code 01 also drops out on undervoltage
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			active_mode <= 1'b0;
			sil_cnt_reg <= 17'h0_0000;
		end else if (ce) begin
			active_mode <= normal_mode && !tx_timeout &&
				(transceiver_mode_sel_reg == 2'b01 || transceiver_mode_sel_reg == 2'b10) &&
				(!supply_low || (active_mode && transceiver_mode_sel_reg == 2'b10));
			if (rx_edge)
				sil_cnt_reg <= 17'h0_0000;
			else if (sil_cnt_reg != SILENCE_CYC)
				sil_cnt_reg <= sil_cnt_reg + 17'h0_0001;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg               <= S_IDLE;
			cnt_reg              <= 6'h00;
			sh_reg               <= 40'h00_0000_0000;
			crc_reg              <= 15'h0000;
			ide_reg              <= 1'b0;
			rtr_reg              <= 1'b0;
			rdlc_reg             <= 4'h0;
			rn_reg               <= 4'h0;
			idm_reg              <= 1'b0;
			dmatch_reg           <= 1'b0;
			crc_ok_reg           <= 1'b0;
			ecnt_reg             <= 6'h00;
			frame_error_overflow <= 1'b0;
			wake_hit_reg         <= 1'b0;
			mon_q_reg            <= 1'b0;
		end else if (ce) begin
			wake_hit_reg <= 1'b0;
			mon_q_reg    <= pn_mon;
			if (!pn_mon) begin
				st_reg <= S_IDLE;
			end else if (err_in) begin
				st_reg <= S_IDLE;
				if (ecnt_reg == `ERR_MAX) begin
					frame_error_overflow <= 1'b1;
					wake_hit_reg         <= 1'b1;
				end
				if (ecnt_reg != `ERR_OVF)
					ecnt_reg <= ecnt_reg + 6'h01;
			end else begin
				case (st_reg)
				S_IDLE:  if (bus_idle) st_reg <= S_READY;
				S_READY: if (bit_vld && !bval) begin
					st_reg  <= S_HDR;
					cnt_reg <= 6'h01;
					crc_reg <= 15'h0000;
					sh_reg  <= 40'h00_0000_0000;
					ide_reg <= 1'b0;
				end
				S_HDR: if (bit_vld) begin
					sh_reg  <= sh_nx;
					crc_reg <= crc_nx;
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == 6'h0D)
						ide_reg <= bval;
					if (hdr_last) begin
						cnt_reg    <= 6'h00;
						rtr_reg    <= sh_nx[6];
						rdlc_reg   <= sh_nx[3:0];
						rn_reg     <= rx_n;
						dmatch_reg <= 1'b0;
						idm_reg    <= ((rx_id ^ id_reg) & cmp_m) == 29'h0000_0000 &&
							ide_reg == id_extended_select_reg;
						if (fdf) begin
							st_reg <= S_IDLE;
							if (!fd_tolerance_en_reg) begin
								if (ecnt_reg == `ERR_MAX) begin
									frame_error_overflow <= 1'b1;
									wake_hit_reg         <= 1'b1;
								end
								if (ecnt_reg != `ERR_OVF)
									ecnt_reg <= ecnt_reg + 6'h01;
							end else if (ecnt_reg != 6'h00) begin
								ecnt_reg <= ecnt_reg - 6'h01;
							end
						end else begin
							st_reg <= (rx_n == 4'h0) ? S_CRC : S_DATA;
						end
					end
				end
				S_DATA: if (bit_vld) begin
					sh_reg  <= sh_nx;
					crc_reg <= crc_nx;
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg[2:0] == 3'h7 && (sh_nx[7:0] & dm_rd_a) != 8'h00)
						dmatch_reg <= 1'b1;
					if (cnt_reg[2:0] == 3'h7 && cnt_reg[5:3] == rn_m1) begin
						st_reg  <= S_CRC;
						cnt_reg <= 6'h00;
					end
				end
				S_CRC: if (bit_vld) begin
					crc_reg <= crc_nx;
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == 6'h0E) begin
						st_reg     <= S_DEL;
						crc_ok_reg <= (crc_nx == 15'h0000);
					end
				end
				S_DEL: if (bit_vld) begin
					// Acknowledge and end of frame are not decoded; wait for idle instead
					st_reg <= S_IDLE;
					if (bval && crc_ok_reg) begin
						if (ecnt_reg != 6'h00)
							ecnt_reg <= ecnt_reg - 6'h01;
						wake_hit_reg <= frm_wake;
					end else begin
						if (ecnt_reg == `ERR_MAX) begin
							frame_error_overflow <= 1'b1;
							wake_hit_reg         <= 1'b1;
						end
						if (ecnt_reg != `ERR_OVF)
							ecnt_reg <= ecnt_reg + 6'h01;
					end
				end
				default: st_reg <= S_IDLE;
				endcase
			end
			if (pn_mon && !mon_q_reg && !bias_on) begin
				ecnt_reg             <= 6'h00;
				frame_error_overflow <= 1'b0;
			end
		end
	end

	// A new wake event wins over a clear arriving in the same cycle
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			bus_wake_flag <= 1'b0;
		else if (ce) begin
			if ((wake_hit_reg && offline && bus_wake_en) ||
				(std_wake_pattern && offline && bus_wake_en && !pn_on))
				bus_wake_flag <= 1'b1;
			else if (wake_clr)
				bus_wake_flag <= 1'b0;
		end
	end
endmodule // can_selective_wake_filter

// [include/can_swf_defs.vh]
// Register map, field positions, reset values and timing counts of the wake filter
`ifndef CAN_SWF_DEFS_VH
`define CAN_SWF_DEFS_VH
`define A_CTRL    7'h20
`define A_STAT    7'h22
`define A_RATE    7'h26
`define A_ID0     7'h27
`define A_ID1     7'h28
`define A_ID2     7'h29
`define A_ID3     7'h2A
`define A_MSK0    7'h2B
`define A_MSK1    7'h2C
`define A_MSK2    7'h2D
`define A_MSK3    7'h2E
`define A_FCTL    7'h2F
`define A_DM_HI   4'hD
`define C_FD      6
`define C_CFG     5
`define C_SEL     4
`define F_IDE     7
`define F_DATA_FILTER_EN    6
`define CTRL_RST  8'h00
`define FCTL_RST  8'h40
`define RATE_RST  3'h5
`define DM_RST    8'hFF
`define ID_RST    29'h0000_0000
`define ERR_MAX   6'h1F
`define ERR_OVF   6'h20
`define CRC_POLY  15'h4599
`define CLK_NS    8
`define BT50_NS   20000
`define BT100_NS  10000
`define BT125_NS  8000
`define BT250_NS  4000
`define BT500_NS  2000
`define BT1M_NS   1000
`define CYC50     (`BT50_NS / `CLK_NS)
`define CYC100    (`BT100_NS / `CLK_NS)
`define CYC125    (`BT125_NS / `CLK_NS)
`define CYC250    (`BT250_NS / `CLK_NS)
`define CYC500    (`BT500_NS / `CLK_NS)
`define CYC1M     (`BT1M_NS / `CLK_NS)
`define IDLE_BITS 4'hA
`endif

// [hdl/can_dmask_mem.v]
// Eight data mask bytes with one write port and two registered read ports
`include "can_swf_defs.vh"
module can_dmask_mem (
	input  wire       mclk,
	input  wire       rst_b,
	input  wire       ce,
	input  wire       we,
	input  wire [2:0] waddr,
	input  wire [7:0] wdata,
	input  wire [2:0] ra_a,
	output reg  [7:0] rd_a,
	input  wire [2:0] ra_b,
	output reg  [7:0] rd_b
);
	wire [63:0] flat;
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_ent
			reg [7:0] ent_reg;
			always @(posedge mclk or negedge rst_b) begin
				if (!rst_b)
					ent_reg <= `DM_RST;
				else if (ce && we && waddr == i)
					ent_reg <= wdata;
			end
			assign flat[i*8 +: 8] = ent_reg;
		end
	endgenerate
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_a <= 8'h00;
			rd_b <= 8'h00;
		end else if (ce) begin
			rd_a <= flat[ra_a*8 +: 8];
			rd_b <= flat[ra_b*8 +: 8];
		end
	end
endmodule // can_dmask_mem

// [hdl/can_bit_sampler.v]
// Bus input synchroniser, bit timing, destuffing and idle detection
`include "can_swf_defs.vh"
module can_bit_sampler (
	input  wire       mclk,
	input  wire       rst_b,
	input  wire       ce,
	input  wire       rx_pin,
	input  wire [2:0] rate_sel,
	input  wire       stuff_en,
	output reg        bit_vld,
	output reg        bit_val,
	output reg        stuff_err,
	output reg        bus_idle,
	output reg        rx_edge
);
	reg  [2:0]  sync_reg;
	reg         rx_reg;
	reg  [11:0] ph_reg;
	reg  [2:0]  run_reg;
	reg         last_reg;
	reg  [3:0]  idle_cnt_reg;
	reg  [31:0] per;
	wire [11:0] per12 = per[11:0];
	wire        chg   = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != rx_reg);
	wire        samp  = (ph_reg == {1'b0, per12[11:1]});

	always @* begin
		case (rate_sel)
		3'h0:    per = `CYC50;
		3'h1:    per = `CYC100;
		3'h2:    per = `CYC125;
		3'h3:    per = `CYC250;
		3'h7:    per = `CYC1M;
		default: per = `CYC500;
		endcase
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync_reg     <= 3'h7;
			rx_reg       <= 1'b1;
			ph_reg       <= 12'h000;
			run_reg      <= 3'h0;
			last_reg     <= 1'b1;
			idle_cnt_reg <= 4'h0;
			bit_vld      <= 1'b0;
			bit_val      <= 1'b1;
			stuff_err    <= 1'b0;
			bus_idle     <= 1'b0;
			rx_edge      <= 1'b0;
		end else if (ce) begin
			sync_reg  <= {sync_reg[1:0], rx_pin};
			bit_vld   <= 1'b0;
			stuff_err <= 1'b0;
			rx_edge   <= chg;
			if (chg)
				rx_reg <= sync_reg[2];
			// Hard sync on every falling edge keeps the sample point centred without a full resync
			if (chg && !sync_reg[2])
				ph_reg <= 12'h000;
			else if (ph_reg >= per12 - 12'h001)
				ph_reg <= 12'h000;
			else
				ph_reg <= ph_reg + 12'h001;
			if (samp) begin
				if (rx_reg) begin
					if (idle_cnt_reg != 4'hF)
						idle_cnt_reg <= idle_cnt_reg + 4'h1;
					if (idle_cnt_reg >= `IDLE_BITS)
						bus_idle <= 1'b1;
				end else begin
					idle_cnt_reg <= 4'h0;
				end
				if (!stuff_en) begin
					run_reg  <= 3'h1;
					last_reg <= rx_reg;
					bit_vld  <= 1'b1;
					bit_val  <= rx_reg;
					if (!rx_reg)
						bus_idle <= 1'b0;
				end else if (run_reg == 3'h5) begin
					stuff_err <= (rx_reg == last_reg);
					run_reg   <= 3'h1;
					last_reg  <= rx_reg;
				end else begin
					bit_vld  <= 1'b1;
					bit_val  <= rx_reg;
					run_reg  <= (rx_reg == last_reg) ? run_reg + 3'h1 : 3'h1;
					last_reg <= rx_reg;
				end
			end
		end
	end
endmodule // can_bit_sampler

// [verification/can_bus_node.sv]
// Bus node model: classic base-format frames and stuff-error bursts
module can_bus_node #(
	parameter int BIT_NS = 1000
) (
	output logic can_rx
);
	timeunit 1ns;
	timeprecision 1ps;

	// Recessive while released: the bus is biased, never floating
	initial can_rx = 1'b1;

	task automatic drv(input logic b, input int n);
		can_rx = b;
		#(BIT_NS * n);
	endtask

	// Sends idle, then start of frame through the crc delimiter
	task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] data_length_setting,
		input logic [7:0] dat, input logic bad);
		logic q[$];
		logic [14:0] crc;
		logic last;
		int run;
		q = {1'b0};
		for (int i = 10; i >= 0; i--) q.push_back(id[i]);
		q = {q, rtr, 1'b0, 1'b0, data_length_setting[3], data_length_setting[2], data_length_setting[1], data_length_setting[0]};
		for (int b = 0; b < 8 * data_length_setting; b++) if (!rtr) q.push_back(dat[7 - b % 8]);
		crc = 15'h0000;
		foreach (q[i]) crc = {crc[13:0], 1'b0} ^ ((q[i] ^ crc[14]) ? 15'h4599 : 15'h0000);
		crc[0] = crc[0] ^ bad;
		for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
		drv(1'b1, 11);
		run = 0;
		foreach (q[i]) begin
			run = (i > 0 && q[i] == last) ? run + 1 : 1;
			last = q[i];
			drv(last, 1);
			if (run == 5) begin
				last = !last;
				drv(last, 1);
				run = 1;
			end
		end
		drv(1'b1, 1);
	endtask

	// Six equal dominant bits from start of frame break the stuffing rule
	task automatic burst();
		drv(1'b0, 6);
		drv(1'b1, 11);
	endtask
endmodule // can_bus_node

// [verification/can_swf_properties.sv]
// Concurrent checks on the wake filter's pins
module can_swf_properties #(
	parameter [16:0] SILENCE_CYC = 17'h1_E848
) (
	input wire mclk,
	input wire rst_b,
	input wire normal_mode,
	input wire bus_wake_en,
	input wire tx_timeout,
	input wire bias_on,
	input wire std_wake_pattern,
	input wire wake_clr,
	input wire bus_wake_flag,
	input wire frame_error_overflow,
	input wire active_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	wake_gate_a: assert property (!bus_wake_en && !bus_wake_flag |=> !bus_wake_flag)
		else $error("wake flag rose with bus wake disabled");
	wake_offline_a: assert property ($rose(bus_wake_flag) |-> !active_mode)
		else $error("wake flag rose in active mode");
	flag_hold_a: assert property (bus_wake_flag && !wake_clr |=> bus_wake_flag)
		else $error("wake flag dropped without clear");
	flag_clear_a: assert property (wake_clr && !std_wake_pattern |=> !bus_wake_flag)
		else $error("wake flag not cleared");
	ovf_wake_a: assert property ($rose(frame_error_overflow) |-> ##[0:2] bus_wake_flag)
		else $error("overflow without wake");
	ovf_hold_a: assert property (frame_error_overflow && bias_on |=> frame_error_overflow)
		else $error("overflow flag dropped with bias on");
	ovf_enabled_a: assert property ($rose(frame_error_overflow) |-> bus_wake_en)
		else $error("overflow while bus wake disabled");
	active_normal_a: assert property (!normal_mode [*3] |-> !active_mode)
		else $error("active outside normal mode");
	txto_active_a: assert property (tx_timeout [*3] |-> !active_mode)
		else $error("active during transmit timeout");
endmodule // can_swf_properties

bind can_selective_wake_filter can_swf_properties #(.SILENCE_CYC(SILENCE_CYC)) u_props (
	.mclk(mclk), .rst_b(rst_b), .normal_mode(normal_mode), .bus_wake_en(bus_wake_en),
	.tx_timeout(tx_timeout), .bias_on(bias_on), .std_wake_pattern(std_wake_pattern),
	.wake_clr(wake_clr), .bus_wake_flag(bus_wake_flag),
	.frame_error_overflow(frame_error_overflow), .active_mode(active_mode)
);

// [verification/can_selective_wake_filter_bench.sv]
// Self-checking bench: serial register access and bus frames
`include "can_swf_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t ns got %h exp %h", $time, g, e); end end
module can_selective_wake_filter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1;
	logic spi_sck = 1'b0, spi_sdi = 1'b0, spi_cs_b = 1'b1, normal_mode = 1'b0;
	logic bus_wake_en = 1'b0, supply_low = 1'b0, osc_locked = 1'b1, tx_timeout = 1'b0;
	logic bias_on = 1'b0, std_wake_pattern = 1'b0, wake_clr = 1'b0;
	logic spi_sdo, spi_sdo_oe, can_rx, bus_wake_flag, frame_error_overflow, active_mode;
	int error_cnt = 0;
	int compares = 0;
	logic [33:0] fr [8];
	logic [7:0] f, dt;
	logic [10:0] id;
	logic [3:0] dl;
	logic rt, bd, ex;

	// Short silence count keeps the status bit reachable in a short run
	can_selective_wake_filter #(.SILENCE_CYC(17'h0_00C8)) u_dut (.mclk(mclk), .rst_b(rst_b),
		.ce(ce), .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_cs_b(spi_cs_b), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .can_rx(can_rx), .normal_mode(normal_mode),
		.bus_wake_en(bus_wake_en), .supply_low(supply_low), .osc_locked(osc_locked),
		.tx_timeout(tx_timeout), .bias_on(bias_on), .std_wake_pattern(std_wake_pattern),
		.wake_clr(wake_clr), .bus_wake_flag(bus_wake_flag),
		.frame_error_overflow(frame_error_overflow), .active_mode(active_mode));
	can_bus_node u_node (.can_rx(can_rx));

	always #4 mclk = ~mclk;

	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Half periods of 8 cycles leave room for the pin synchronisers
	task spi(input logic [6:0] a, input logic r, input logic [7:0] w, output logic [7:0] q);
		logic [15:0] sh;
		sh = {a, r, w};
		q = 8'h00;
		spi_cs_b = 1'b0;
		tick(8);
		for (int i = 15; i >= 0; i--) begin
			spi_sdi = sh[i];
			tick(8);
			if (i < 8) q = {q[6:0], spi_sdo};
			spi_sck = 1'b1;
			tick(8);
			spi_sck = 1'b0;
		end
		tick(8);
		spi_cs_b = 1'b1;
		tick(8);
	endtask

	task wr(input logic [6:0] a, input logic [7:0] w);
		logic [7:0] q;
		spi(a, 1'b0, w, q);
	endtask

	task rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		spi(a, 1'b1, 8'h00, q);
		`CHK(q, e)
		`CHK(spi_sdo_oe, 1'b0)
	endtask

	// A ref argument makes the pulse visible to the design while the task runs
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(3);
	endtask

	task summarize;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#1_400_000;
		error_cnt++;
		$display("[FAIL] %0t ns watchdog expired", $time);
		summarize();
	end

	initial begin
		fr = '{{8'h41, 11'h1A5, 1'b0, 4'h1, 8'h10, 1'b0, 1'b0},
			{8'h41, 11'h1A5, 1'b0, 4'h1, 8'h08, 1'b0, 1'b1},
			{8'h41, 11'h1A0, 1'b0, 4'h2, 8'hFF, 1'b0, 1'b0},
			{8'h41, 11'h1A8, 1'b0, 4'h1, 8'hFF, 1'b0, 1'b0},
			{8'h41, 11'h1A0, 1'b1, 4'h1, 8'hFF, 1'b0, 1'b0},
			{8'h01, 11'h1A3, 1'b1, 4'h1, 8'hFF, 1'b0, 1'b1},
			{8'h01, 11'h1A3, 1'b0, 4'h1, 8'hFF, 1'b1, 1'b0},
			{8'h40, 11'h1A0, 1'b0, 4'h0, 8'h00, 1'b0, 1'b1}};
		tick(8);
		rst_b = 1'b1;
		tick(300);
		rd(`A_CTRL, 8'h00);
		rd(`A_FCTL, 8'h40);
		rd(`A_RATE, 8'h05);
		rd(7'h6F, 8'hFF);
		wr(`A_STAT, 8'hFF);
		rd(`A_STAT, 8'h58);
		rd(7'h10, 8'h00);
		$display("registers done");
		pulse(std_wake_pattern);
		`CHK(bus_wake_flag, 1'b0)
		bus_wake_en = 1'b1;
		pulse(std_wake_pattern);
		`CHK(bus_wake_flag, 1'b1)
		pulse(wake_clr);
		`CHK(bus_wake_flag, 1'b0)
		$display("standard wake done");
		normal_mode = 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(`A_CTRL, 8'(m));
			rd(`A_STAT, {m == 1 || m == 2, 7'h58});
			`CHK(active_mode, m == 1 || m == 2)
		end
		tx_timeout = 1'b1;
		rd(`A_STAT, 8'h59);
		tx_timeout = 1'b0;
		supply_low = 1'b1;
		osc_locked = 1'b0;
		wr(`A_CTRL, 8'h01);
		rd(`A_STAT, 8'h4A);
		`CHK(active_mode, 1'b0)
		osc_locked = 1'b1;
		supply_low = 1'b0;
		normal_mode = 1'b0;
		$display("modes done");
		wr(`A_RATE, 8'h07);
		wr(`A_ID2, 8'h80);
		wr(`A_ID3, 8'h06);
		wr(`A_MSK2, 8'h1C);
		wr(7'h6F, 8'hA8);
		wr(`A_CTRL, 8'h30);
		rd(`A_STAT, 8'h38);
		wr(7'h6E, 8'h00);
		rd(`A_STAT, 8'h58);
		foreach (fr[k]) begin
			{f, id, rt, dl, dt, bd, ex} = fr[k];
			wr(`A_FCTL, f);
			wr(`A_CTRL, 8'h30);
			u_node.send(id, rt, dl, dt, bd);
			tick(4);
			`CHK(bus_wake_flag, ex)
			pulse(wake_clr);
		end
		$display("frames done");
		bias_on = 1'b1;
		// The decoder only counts errors after a full idle, so the first burst needs one
		u_node.drv(1'b1, 11);
		repeat (31) u_node.burst();
		`CHK(frame_error_overflow, 1'b0)
		u_node.burst();
		`CHK(frame_error_overflow, 1'b1)
		`CHK(bus_wake_flag, 1'b1)
		rd(`A_STAT, 8'h78);
		bias_on = 1'b0;
		wr(`A_CTRL, 8'h00);
		wr(`A_CTRL, 8'h30);
		tick(4);
		`CHK(frame_error_overflow, 1'b0)
		$display("error counter done");
		summarize();
	end
endmodule // can_selective_wake_filter_bench
